/* csk_compare_skip.sv */
// Purpose: execution of the compare-file-with-working-register-and-skip instructions
// Assumes: fetch holds the word and its successor length while instrValid is high
// Notes: memory read data is valid in the clock after memRdEn_q
// How it works
// (RULE1) high byte 0110 010a skips the next instruction when file exceeds working register
// (RULE2) high byte 0110 000a skips the next instruction when file is below working register
// (RULE3) compare by unsigned subtraction, result only decides the skip
// (RULE4) on skip the prefetched instruction is discarded and a no-op cycle runs
// (RULE5) one word; one cycle without skip, two when skipping a one-word instruction
// (RULE6) skipping a two-word instruction takes three cycles, later ones all no-op
// (RULE7) skipping a three-word instruction takes four cycles, each following word flushed
// (RULE8) bank bit 0 picks the access bank, 1 picks the bank register's bank
// (RULE9) bank bit 0, extended set on and file at most 95 gives indexed literal offset
// (RULE10) equal variant skips the following instruction when file equals working register
// (RULE11) no flags, working register or file are written; Q4 does no write-back
// (RULE12) Q1 decodes, Q2 reads the file, Q3 compares before the next fetch executes
`timescale 1ns/100ps
module csk_compare_skip (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instrValid,
  input csk_pkg::csk_instr_t instr,
  input wire logic [1:0] nextWords,
  input wire logic [15:0] pcIn,
  input csk_pkg::csk_core_t core,
  input wire logic [7:0] memRdData,
  output logic busy_q,
  output logic [1:0] phase_q,
  output logic memRdEn_q,
  output logic [11:0] memAddr_q,
  output logic modeIndexed_q,
  output logic skip_q,
  output logic nopCycle_q,
  output logic writeBack_q,
  output logic pcValid_q,
  output logic [15:0] pcNext_q
);
  import csk_pkg::*;

  csk_state_t state_q, state_d;
  csk_kind_t kind_q, kind_d;
  logic [15:0] pc_q, pc_d;
  logic [1:0] len_q, len_d;
  logic [3:0] cnt_q, cnt_d;
  logic busy_d;
  logic [1:0] phase_d;
  logic memRdEn_d;
  logic [11:0] memAddr_d;
  logic modeIndexed_d;
  logic skip_d;
  logic nopCycle_d;
  logic pcValid_d;
  logic [15:0] pcNext_d;
  logic isCmp;
  logic accept;
  logic indexed;
  logic [11:0] addr;
  logic [1:0] lenIn;
  logic skipNow;
  csk_flags_t flags;

  csk_cmp u_cmp (
    .fileVal(memRdData),
    .workReg(core.workReg),
    .flags(flags)
  );

  always_comb begin
    // decode in Q1 of an idle slot
    isCmp = (instr.opHi == CSK_OP_HI) && ((instr.sel == CSK_SEL_GT) || (instr.sel == CSK_SEL_LT)
            || (instr.sel == CSK_SEL_EQ)); // RULE1 RULE2 RULE10
    accept = (state_q == CSK_ST_IDLE) && instrValid && isCmp; // RULE12
    lenIn = (nextWords == 2'h0) ? CSK_LEN_MIN : nextWords;
    // operand address
    indexed = !instr.bankSel && core.extEn && (instr.file <= CSK_IDX_LIMIT); // RULE9
    if (indexed) begin
      addr = core.idxBase + {4'h0, instr.file}; // RULE9
    end else if (instr.bankSel) begin
      addr = {core.bankReg, instr.file}; // RULE8
    end else if (instr.file <= CSK_IDX_LIMIT) begin
      addr = {CSK_ACC_LOW_BANK, instr.file}; // RULE8
    end else begin
      addr = {CSK_ACC_HIGH_BANK, instr.file}; // RULE8
    end
    // skip decision from the unsigned compare
    case (kind_q)
      CSK_KIND_GT: skipNow = flags.gt; // RULE1
      CSK_KIND_LT: skipNow = flags.lt; // RULE2
      CSK_KIND_EQ: skipNow = flags.eq; // RULE10
      default: skipNow = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    pc_d = pc_q;
    len_d = len_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    phase_d = phase_q;
    memRdEn_d = 1'b0;
    memAddr_d = memAddr_q;
    modeIndexed_d = modeIndexed_q;
    skip_d = skip_q;
    nopCycle_d = nopCycle_q;
    pcValid_d = 1'b0;
    pcNext_d = pcNext_q;
    case (state_q)
      CSK_ST_IDLE: begin
        phase_d = CSK_PH_Q1;
        busy_d = 1'b0;
        if (accept) begin
          state_d = CSK_ST_EXEC;
          if (instr.sel == CSK_SEL_GT) begin
            kind_d = CSK_KIND_GT;
          end else if (instr.sel == CSK_SEL_LT) begin
            kind_d = CSK_KIND_LT;
          end else begin
            kind_d = CSK_KIND_EQ;
          end
          pc_d = pcIn;
          len_d = lenIn;
          busy_d = 1'b1;
          phase_d = CSK_PH_Q2;
          memRdEn_d = 1'b1; // RULE12
          memAddr_d = addr;
          modeIndexed_d = indexed;
          skip_d = 1'b0;
        end
      end
      CSK_ST_EXEC: begin
        if (phase_q == CSK_PH_Q2) begin
          phase_d = CSK_PH_Q3;
        end else if (phase_q == CSK_PH_Q3) begin
          phase_d = CSK_PH_Q4;
          skip_d = skipNow; // RULE3 RULE12
        end else begin
          // Q4 is a no-op, nothing written back
          phase_d = CSK_PH_Q1;
          if (skip_q) begin
            state_d = CSK_ST_FLUSH; // RULE4
            nopCycle_d = 1'b1;
            cnt_d = 4'(int'(len_q) * CSK_PHASES) - CSK_CNT_ONE; // RULE6 RULE7
          end else begin
            state_d = CSK_ST_IDLE; // RULE5
            busy_d = 1'b0;
            pcValid_d = 1'b1;
            pcNext_d = pc_q + CSK_WORD_BYTES; // RULE10
          end
        end
      end
      CSK_ST_FLUSH: begin
        // every phase of every flushed word is a no-op
        phase_d = phase_q + 2'h1;
        cnt_d = cnt_q - CSK_CNT_ONE;
        if (cnt_q == CSK_CNT_ZERO) begin
          state_d = CSK_ST_IDLE;
          busy_d = 1'b0;
          nopCycle_d = 1'b0;
          pcValid_d = 1'b1;
          pcNext_d = pc_q + CSK_WORD_BYTES + {13'h0000, len_q, 1'b0}; // RULE10 RULE6 RULE7
        end
      end
      default: begin
        state_d = CSK_ST_IDLE;
        nopCycle_d = 1'b0;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= CSK_ST_IDLE;
      kind_q <= CSK_KIND_LT;
      pc_q <= CSK_PC_RST;
      len_q <= CSK_LEN_MIN;
      cnt_q <= CSK_CNT_ZERO;
      busy_q <= 1'b0;
      phase_q <= CSK_PH_Q1;
      memRdEn_q <= 1'b0;
      memAddr_q <= CSK_ADDR_RST;
      modeIndexed_q <= 1'b0;
      skip_q <= 1'b0;
      nopCycle_q <= 1'b0;
      writeBack_q <= 1'b0;
      pcValid_q <= 1'b0;
      pcNext_q <= CSK_PC_RST;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      pc_q <= pc_d;
      len_q <= len_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      phase_q <= phase_d;
      memRdEn_q <= memRdEn_d;
      memAddr_q <= memAddr_d;
      modeIndexed_q <= modeIndexed_d;
      skip_q <= skip_d;
      nopCycle_q <= nopCycle_d;
      writeBack_q <= 1'b0; // RULE11
      pcValid_q <= pcValid_d;
      pcNext_q <= pcNext_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_read_in_q2: assert property (accept |=> memRdEn_q && (phase_q == CSK_PH_Q2) ##1 !memRdEn_q) // RULE12
    else $error("file read not issued in Q2");
  a_gt_skip: assert property ((state_q == CSK_ST_EXEC) && (phase_q == CSK_PH_Q3) && (kind_q == CSK_KIND_GT) // RULE1
    |=> skip_q == ($past(memRdData) > $past(core.workReg)))
    else $error("greater skip decision wrong");
  a_lt_skip: assert property ((state_q == CSK_ST_EXEC) && (phase_q == CSK_PH_Q3) && (kind_q == CSK_KIND_LT) // RULE2
    |=> skip_q == ($past(memRdData) < $past(core.workReg)))
    else $error("less skip decision wrong");
  a_eq_skip: assert property ((state_q == CSK_ST_EXEC) && (phase_q == CSK_PH_Q3) // RULE10 RULE3
    && (kind_q == CSK_KIND_EQ) |=> skip_q == ($past(memRdData) == $past(core.workReg)))
    else $error("equal skip decision wrong");
  a_nop_after_skip: assert property ((state_q == CSK_ST_EXEC) && (phase_q == CSK_PH_Q4) && skip_q // RULE4
    |=> nopCycle_q[*4])
    else $error("skipped slot not a no-op cycle");
  a_one_cycle: assert property (accept ##3 !skip_q |=> pcValid_q && !nopCycle_q) // RULE5
    else $error("non-skip instruction not one cycle");
  a_two_cycle: assert property (accept && (lenIn == 2'h1) ##3 skip_q |-> ##5 pcValid_q) // RULE5
    else $error("skip of one word not two cycles");
  a_three_cycle: assert property (accept && (lenIn == 2'h2) ##3 skip_q |-> ##1 (nopCycle_q && !pcValid_q)[*8] // RULE6
    ##1 pcValid_q)
    else $error("skip of two words not three cycles");
  a_four_cycle: assert property (accept && (lenIn == 2'h3) ##3 skip_q |-> ##13 pcValid_q) // RULE7
    else $error("skip of three words not four cycles");
  a_bank_addr: assert property (accept && instr.bankSel // RULE8
    |=> memAddr_q == {$past(core.bankReg), $past(instr.file)})
    else $error("banked address wrong");
  a_indexed_addr: assert property (accept && !instr.bankSel && core.extEn && (instr.file <= CSK_IDX_LIMIT) // RULE9
    |=> modeIndexed_q && (memAddr_q == $past(core.idxBase) + {4'h0, $past(instr.file)}))
    else $error("indexed literal offset address wrong");
  a_pc_target: assert property (pcValid_q |-> pcNext_q == (skip_q // RULE10
    ? pc_q + CSK_WORD_BYTES + {13'h0000, len_q, 1'b0} : pc_q + CSK_WORD_BYTES))
    else $error("next program counter wrong");
  a_no_writeback: assert property (busy_q |-> !writeBack_q) // RULE11
    else $error("write-back during compare");

  c_no_skip: cover property (accept ##3 !skip_q ##1 pcValid_q);
  c_skip_one: cover property (accept && (lenIn == 2'h1) ##3 skip_q);
  c_skip_three: cover property (accept && (lenIn == 2'h3) ##3 skip_q);
  c_indexed: cover property (accept && indexed);
endmodule

/* csk_pkg.sv */
// Purpose: shared constants and types of the compare-skip unit
// Assumes: one instruction cycle is four clk_sys periods (Q1..Q4)
// Notes: program counter counts bytes, one program word is two bytes
package csk_pkg;
  // phase counter and timing
  localparam int CSK_PHASES = 4;
  localparam logic [1:0] CSK_PH_Q1 = 2'h0;
  localparam logic [1:0] CSK_PH_Q2 = 2'h1;
  localparam logic [1:0] CSK_PH_Q3 = 2'h2;
  localparam logic [1:0] CSK_PH_Q4 = 2'h3;
  localparam logic [3:0] CSK_CNT_ONE = 4'h1;
  localparam logic [3:0] CSK_CNT_ZERO = 4'h0;
  // opcode fields
  localparam logic [3:0] CSK_OP_HI = 4'h6;
  localparam logic [2:0] CSK_SEL_LT = 3'h0;
  localparam logic [2:0] CSK_SEL_EQ = 3'h1;
  localparam logic [2:0] CSK_SEL_GT = 3'h2;
  // addressing
  localparam logic [7:0] CSK_IDX_LIMIT = 8'h5f;
  localparam logic [3:0] CSK_ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] CSK_ACC_HIGH_BANK = 4'hf;
  // program counter and reset values
  localparam logic [15:0] CSK_WORD_BYTES = 16'h0002;
  localparam logic [15:0] CSK_PC_RST = 16'h0000;
  localparam logic [11:0] CSK_ADDR_RST = 12'h000;
  localparam logic [1:0] CSK_LEN_MIN = 2'h1;

  typedef enum logic [1:0] {CSK_KIND_LT, CSK_KIND_EQ, CSK_KIND_GT} csk_kind_t;
  typedef enum logic [1:0] {CSK_ST_IDLE, CSK_ST_EXEC, CSK_ST_FLUSH} csk_state_t;

  typedef struct packed {
    logic [3:0] opHi;
    logic [2:0] sel;
    logic bankSel;
    logic [7:0] file;
  } csk_instr_t;

  typedef struct packed {
    logic [7:0] workReg;
    logic [3:0] bankReg;
    logic [11:0] idxBase;
    logic extEn;
  } csk_core_t;

  typedef struct packed {
    logic gt;
    logic lt;
    logic eq;
  } csk_flags_t;
endpackage

/* csk_cmp.sv */
// Purpose: unsigned compare of a file byte against the working register
// Assumes: both operands are plain unsigned bytes
// Notes: the difference only feeds the flags, it is never stored
`timescale 1ns/100ps
module csk_cmp (
  input wire logic [7:0] fileVal,
  input wire logic [7:0] workReg,
  output csk_pkg::csk_flags_t flags
);
  import csk_pkg::*;

  logic [8:0] diff;

  always_comb begin
    // subtract working register from file byte, borrow means below
    diff = {1'b0, fileVal} - {1'b0, workReg}; // RULE3
    flags.lt = diff[8]; // RULE3
    flags.eq = (diff[7:0] == 8'h00);
    flags.gt = !diff[8] && (diff[7:0] != 8'h00);
  end
endmodule

/* csk_compare_skip_tb_top.sv */
// Purpose: self-checking bench of the compare-skip unit
// Assumes: inputs change on the falling edge of clk_sys, one phase per clock
// Notes: expected skip, address, cycle count and next pc are worked out here
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module csk_compare_skip_tb_top;
  import csk_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  csk_instr_t instr = '0;
  logic [1:0] nextWords = 2'h0;
  logic [15:0] pcIn = 16'h0000;
  csk_core_t core = '0;
  logic [7:0] memRdData = 8'h00;
  logic busy_q, memRdEn_q, modeIndexed_q, skip_q, nopCycle_q, writeBack_q, pcValid_q;
  logic [1:0] phase_q;
  logic [11:0] memAddr_q;
  logic [15:0] pcNext_q;
  int num_errors = 0;
  int n_checks = 0;

  csk_compare_skip dut (.clk_sys(clk_sys), .rst(rst), .instrValid(instrValid), .instr(instr),
    .nextWords(nextWords), .pcIn(pcIn), .core(core), .memRdData(memRdData), .busy_q(busy_q),
    .phase_q(phase_q), .memRdEn_q(memRdEn_q), .memAddr_q(memAddr_q), .modeIndexed_q(modeIndexed_q),
    .skip_q(skip_q), .nopCycle_q(nopCycle_q), .writeBack_q(writeBack_q), .pcValid_q(pcValid_q),
    .pcNext_q(pcNext_q));

  always #2 clk_sys = ~clk_sys;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one compare-skip instruction
  task automatic run_op(input string name, input logic [2:0] sel, input logic bs, input logic [7:0] f,
      input logic [7:0] w, input logic [7:0] m, input logic [1:0] nw, input logic ext);
    logic expSkip;
    logic expIdx;
    logic [11:0] expAddr;
    logic [15:0] expPc;
    int len;
    int n;
    int nops;
    int rds;
    expSkip = (sel == CSK_SEL_LT) ? (m < w) : ((sel == CSK_SEL_EQ) ? (m == w) : (m > w));
    len = (nw == 2'h0) ? 1 : int'(nw);
    expIdx = !bs && ext && (f <= CSK_IDX_LIMIT);
    if (bs) begin
      expAddr = {4'h3, f};
    end else if (expIdx) begin
      expAddr = 12'h120 + {4'h0, f};
    end else begin
      expAddr = (f <= CSK_IDX_LIMIT) ? {CSK_ACC_LOW_BANK, f} : {CSK_ACC_HIGH_BANK, f};
    end
    expPc = {8'h01, f} + CSK_WORD_BYTES + (expSkip ? 16'(2 * len) : 16'h0000);
    @(negedge clk_sys);
    instrValid = 1'b1;
    instr = '{opHi: CSK_OP_HI, sel: sel, bankSel: bs, file: f};
    nextWords = nw;
    pcIn = {8'h01, f};
    core = '{workReg: w, bankReg: 4'h3, idxBase: 12'h120, extEn: ext};
    memRdData = ~m;
    n = 0;
    nops = 0;
    rds = 0;
    @(posedge clk_sys);
    while (pcValid_q !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
      if (memRdEn_q === 1'b1) begin
        rds++;
        memRdData = m;
        `CHK(memAddr_q, expAddr)
        `CHK(modeIndexed_q, expIdx)
      end
      if (n == 1) `CHK(phase_q, CSK_PH_Q2)
      if (n == 2) instrValid = 1'b0;
      if (n == 3) `CHK(skip_q, expSkip)
      if (nopCycle_q === 1'b1) nops++;
      `CHK(writeBack_q, 1'b0)
    end
    if (pcValid_q !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    `CHK(rds, 1)
    `CHK(skip_q, expSkip)
    `CHK(n, expSkip ? 4 + 4 * len : 4)
    `CHK(nops, expSkip ? 4 * len : 0)
    `CHK(pcNext_q, expPc)
    `CHK(busy_q, 1'b0)
    memRdData = ~m;
    $display("test %s done", name);
  endtask

  // words that are not compare-skip instructions never start an operation
  task automatic ignore_op;
    int i;
    @(negedge clk_sys);
    instrValid = 1'b1;
    instr = '{opHi: 4'h7, sel: CSK_SEL_GT, bankSel: 1'b0, file: 8'h10};
    for (i = 0; i < 12; i++) begin
      @(negedge clk_sys);
      if (i == 5) instr = '{opHi: CSK_OP_HI, sel: 3'h3, bankSel: 1'b0, file: 8'h10};
      `CHK(busy_q, 1'b0)
      `CHK(memRdEn_q, 1'b0)
    end
    instrValid = 1'b0;
    $display("test ignore done");
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    `CHK(busy_q, 1'b0)
    run_op("gt_skip_bank", CSK_SEL_GT, 1'b1, 8'h42, 8'h41, 8'h42, 2'h1, 1'b0);
    run_op("gt_equal_noskip", CSK_SEL_GT, 1'b1, 8'h42, 8'h42, 8'h42, 2'h1, 1'b0);
    run_op("gt_unsigned_idx", CSK_SEL_GT, 1'b0, 8'h5f, 8'h00, 8'hff, 2'h0, 1'b1);
    run_op("lt_skip_two", CSK_SEL_LT, 1'b0, 8'h60, 8'h80, 8'h00, 2'h2, 1'b1);
    run_op("lt_equal_noskip", CSK_SEL_LT, 1'b0, 8'h60, 8'h33, 8'h33, 2'h2, 1'b1);
    run_op("eq_skip_three", CSK_SEL_EQ, 1'b0, 8'h5f, 8'h9c, 8'h9c, 2'h3, 1'b0);
    run_op("eq_noskip", CSK_SEL_EQ, 1'b1, 8'h00, 8'h9c, 8'h9d, 2'h3, 1'b1);
    run_op("lt_unsigned_one", CSK_SEL_LT, 1'b1, 8'hff, 8'h01, 8'hfe, 2'h1, 1'b1);
    ignore_op();
    run_op("gt_after_ignore", CSK_SEL_GT, 1'b0, 8'h00, 8'h7f, 8'h80, 2'h2, 1'b0);
    wrap_up();
  end
endmodule
